/* shared/sbc_pkg.sv */
// shared constants, register map and types of the sensorless commutator
package sbc_pkg;
    localparam int          CLK_HZ          = 250_000_000;
    localparam int          PWM_HZ          = 20_000;
    localparam int          PWM_CYC         = CLK_HZ / PWM_HZ;
    localparam int          ADC_W           = 10;
    localparam logic [9:0]  ADC_FULL        = 10'h3FF;
    localparam int          ACC_W           = 24;
    localparam int          OC_SEL_W        = 2;
    localparam int          OC_REF_W        = 10;
    // comparator references in converter codes, 3.3 V full scale
    localparam logic [9:0]  OC_REF_1V5      = 10'h1D1;
    localparam logic [9:0]  OC_REF_2V0      = 10'h26C;
    localparam logic [9:0]  OC_REF_2V5      = 10'h307;
    // register word offsets
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_FLUX        = 4'h1;
    localparam logic [3:0]  REG_DUTY_MAX    = 4'h2;
    localparam logic [3:0]  REG_DUTY_CMD    = 4'h3;
    localparam logic [3:0]  REG_ALIGN_MAX   = 4'h4;
    localparam logic [3:0]  REG_OL_RATE     = 4'h5;
    localparam logic [3:0]  REG_STATUS      = 4'h6;
    localparam logic [3:0]  REG_IRQ_STAT    = 4'h7;
    localparam logic [3:0]  REG_IRQ_MASK    = 4'h8;
    // reset values
    localparam logic [23:0] FLUX_RST        = 24'h00012C;
    localparam logic [15:0] DUTY_MAX_RST    = 16'h0300;
    localparam logic [6:0]  ALIGN_MAX_RST   = 7'h04;
    localparam logic [15:0] OL_RATE_RST     = 16'h0007;
    localparam logic [6:0]  ALIGN_START_PCT = 7'h01;
    // irq bits
    localparam int          IRQ_COMM        = 0;
    localparam int          IRQ_OC          = 1;
    localparam int          IRQ_CLOSED      = 2;
    localparam int          IRQ_W           = 3;

    typedef enum logic [1:0] { ST_IDLE, ST_ALIGN, ST_OPEN, ST_CLOSED }
        sbc_mode_t;

    // gate drive bundle, one high and one low switch per leg
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } sbc_gate_t;
endpackage

/* rtl/sbc_commutator.sv */
// sensorless back-emf integration commutator with avalon slave
// What this block does
// - one winding conversion is taken every pwm cycle, 50 us at 20 khz
// - samples are 10-bit unsigned, full scale code 1023
// - integrate after open phase crosses half-bus, until sum hits flux limit
// - accumulated back-emf compared against programmable flux limit
// - lower limit commutates earlier, higher limit later
// - alignment duty ramps from 1 percent up to alignment ceiling
// - open-loop acceleration to top rate, then closed-loop commutation
// - overcurrent reference selected among 1.5, 2.0, 2.5 volts
// - only high side is modulated; paired low side stays on
// - each step drives two legs, third leg has both switches off
// - requested duty above ceiling is clamped to the ceiling
// - comparator high turns pwm off for rest of that cycle
module sbc_commutator
    import sbc_pkg::*;
#(
    parameter int PWM_PERIOD = PWM_CYC,
    // first open-loop step length in pwm cycles; shrink it only for sim
    parameter int OL_BASE    = PWM_HZ / 6
)(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [ADC_W-1:0]  adc_phase_i,
    input  wire logic [ADC_W-1:0]  adc_bus_i,
    input  wire logic              adc_valid_i,
    input  wire logic [ADC_W-1:0]  adc_current_i,
    output logic                   adc_start_o,
    output logic [1:0]             adc_chan_o,
    output sbc_gate_t              gate_o,
    output logic                   irq_o
);
    localparam int CW = $clog2(PWM_PERIOD);
    if (PWM_PERIOD < 16 || PWM_PERIOD > 65535 || OL_BASE < 1
        || OL_BASE > 65535)
    begin : g_bad_param
        $error("pwm period or open-loop base out of range");
    end

    // control registers
    logic                 run_q;
    logic [OC_SEL_W-1:0]  oc_sel_q;
    logic [ACC_W-1:0]     flux_q;
    logic [15:0]          duty_max_q, duty_cmd_q, ol_rate_q;
    logic [6:0]           align_max_q;
    logic [IRQ_W-1:0]     irq_stat_q, irq_mask_q, irq_set;
    logic                 ack_q;
    // datapath state
    sbc_mode_t            mode_q;
    logic [CW-1:0]        cnt_q;
    logic [2:0]           step_q;
    logic [ACC_W-1:0]     acc_q;
    logic                 integ_q, oc_q, comm;
    logic [6:0]           align_pct_q;
    logic [15:0]          ol_div_q, ol_per_q, ol_cnt_q;
    logic [1:0][ADC_W-1:0] ph_s, bus_s, cur_s;
    logic [1:0]           val_s;
    logic [15:0]          duty_eff;
    logic [ADC_W-1:0]     oc_ref;
    logic                 pwm_on, new_cyc;
    logic [ADC_W-1:0]     emf;

    // select comparator reference code
    function automatic logic [ADC_W-1:0] oc_level(input logic [1:0] s);
        if (s == 2'h0)      return OC_REF_1V5;
        else if (s == 2'h1) return OC_REF_2V0;
        else                return OC_REF_2V5;
    endfunction

    // two-stage synchronisers for the converter inputs
    always_ff @(posedge ref_clk_i)
    begin
        ph_s  <= rst_n_i ? {ph_s[0], adc_phase_i} : '0;
        bus_s <= rst_n_i ? {bus_s[0], adc_bus_i} : '0;
        cur_s <= rst_n_i ? {cur_s[0], adc_current_i} : '0;
        val_s <= rst_n_i ? {val_s[0], adc_valid_i} : '0;
    end

    // avalon slave, one wait cycle per access
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            // own flop so the bus never sees a decode glitch
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            run_q <= 1'b0;
            oc_sel_q <= '0;
            flux_q <= FLUX_RST;
            duty_max_q <= DUTY_MAX_RST;
            duty_cmd_q <= '0;
            align_max_q <= ALIGN_MAX_RST;
            ol_rate_q <= OL_RATE_RST;
            irq_mask_q <= '0;
        end
        else if (avs_write && !ack_q)
        begin
            if (avs_address == REG_CTRL)
            begin
                run_q <= avs_writedata[0];
                oc_sel_q <= avs_writedata[5:4];
            end
            else if (avs_address == REG_FLUX)
                flux_q <= avs_writedata[ACC_W-1:0];
            else if (avs_address == REG_DUTY_MAX)
                duty_max_q <= avs_writedata[15:0];
            else if (avs_address == REG_DUTY_CMD)
                duty_cmd_q <= avs_writedata[15:0];
            else if (avs_address == REG_ALIGN_MAX)
                align_max_q <= avs_writedata[6:0];
            else if (avs_address == REG_OL_RATE)
                ol_rate_q <= avs_writedata[15:0];
            else if (avs_address == REG_IRQ_MASK)
                irq_mask_q <= avs_writedata[IRQ_W-1:0];
        end
    end

    // read mux; unmapped offsets read zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            avs_readdata <= '0;
        else if (avs_read && !ack_q)
        begin
            if (avs_address == REG_CTRL)
                avs_readdata <= {26'h0, oc_sel_q, 3'h0, run_q};
            else if (avs_address == REG_FLUX)
                avs_readdata <= {8'h0, flux_q};
            else if (avs_address == REG_DUTY_MAX)
                avs_readdata <= {16'h0, duty_max_q};
            else if (avs_address == REG_DUTY_CMD)
                avs_readdata <= {16'h0, duty_cmd_q};
            else if (avs_address == REG_ALIGN_MAX)
                avs_readdata <= {25'h0, align_max_q};
            else if (avs_address == REG_OL_RATE)
                avs_readdata <= {16'h0, ol_rate_q};
            else if (avs_address == REG_STATUS)
                avs_readdata <= {21'h0, oc_q, step_q, 5'h0, mode_q};
            else if (avs_address == REG_IRQ_STAT)
                avs_readdata <= {29'h0, irq_stat_q};
            else if (avs_address == REG_IRQ_MASK)
                avs_readdata <= {29'h0, irq_mask_q};
            else
                avs_readdata <= '0;
        end
    end

    // pwm period counter
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (cnt_q == CW'(PWM_PERIOD - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end
    assign new_cyc = (cnt_q == '0);

    // effective duty: alignment ramp or command, clamped to the ceiling
    always_comb
    begin
        logic [15:0] req;
        req = (mode_q == ST_ALIGN)
            ? 16'((32'(align_pct_q) * PWM_PERIOD) / 100)
            : duty_cmd_q;
        duty_eff = (req > duty_max_q) ? duty_max_q : req;
    end
    assign oc_ref = oc_level(oc_sel_q);

    // overcurrent latch cleared at the next pwm cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            oc_q <= 1'b0;
        else if (cur_s[1] >= oc_ref)
            oc_q <= 1'b1;
        else if (new_cyc)
            oc_q <= 1'b0;
    end
    assign pwm_on = 16'(cnt_q) < duty_eff && !oc_q
                    && !(cur_s[1] >= oc_ref);

    // converter trigger once per pwm cycle, open phase channel
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            adc_start_o <= 1'b0;
            adc_chan_o <= '0;
        end
        else
        begin
            adc_start_o <= new_cyc && run_q;
            // open leg is the one neither pulsed nor held low
            adc_chan_o <= (step_q == 3'd0 || step_q == 3'd3) ? 2'h1
                        : (step_q == 3'd1 || step_q == 3'd4) ? 2'h2 : 2'h0;
        end
    end

    // back-emf integration; odd steps have falling open-phase voltage
    always_comb
    begin
        logic [ADC_W:0] mid;
        mid = {1'b0, bus_s[1]} >> 1;
        if (step_q[0])
            emf = (mid[ADC_W-1:0] > ph_s[1])
                ? mid[ADC_W-1:0] - ph_s[1] : '0;
        else
            emf = (ph_s[1] > mid[ADC_W-1:0])
                ? ph_s[1] - mid[ADC_W-1:0] : '0;
        comm = 1'b0;
        if (mode_q == ST_CLOSED && val_s[1] && integ_q
            && acc_q + ACC_W'(emf) >= flux_q)
            comm = 1'b1;
        else if (mode_q == ST_OPEN && ol_cnt_q >= ol_per_q && new_cyc)
            comm = 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            acc_q <= '0;
            integ_q <= 1'b0;
        end
        else if (comm || mode_q != ST_CLOSED)
        begin
            acc_q <= '0;
            integ_q <= 1'b0;
        end
        else if (val_s[1])
        begin
            if (!integ_q && (step_q[0] ? ph_s[1] <= bus_s[1] >> 1
                                      : ph_s[1] >= bus_s[1] >> 1))
                integ_q <= 1'b1;
            // saturated difference: a dip past the tap must not wrap
            if (integ_q)
                acc_q <= acc_q + ACC_W'(emf);
        end
    end

    // mode sequencer: align ramp, open-loop accel, closed loop
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= ST_IDLE;
            align_pct_q <= ALIGN_START_PCT;
            ol_div_q <= '0;
            ol_per_q <= '0;
            ol_cnt_q <= '0;
            step_q <= '0;
        end
        else if (!run_q)
            mode_q <= ST_IDLE;
        else
        begin
            if (comm)
                step_q <= (step_q == 3'd5) ? 3'd0 : step_q + 3'd1;
            if (new_cyc)
                ol_cnt_q <= comm ? 16'h0 : ol_cnt_q + 16'h1;
            case (mode_q)
                ST_IDLE:
                begin
                    align_pct_q <= ALIGN_START_PCT;
                    mode_q <= ST_ALIGN;
                end
                ST_ALIGN:
                    if (new_cyc)
                    begin
                        if (align_pct_q >= align_max_q)
                        begin
                            mode_q <= ST_OPEN;
                            ol_div_q <= 16'd1;
                            ol_per_q <= 16'(OL_BASE);
                            ol_cnt_q <= 16'h0;
                        end
                        else
                            align_pct_q <= align_pct_q + 7'd1;
                    end
                ST_OPEN:
                    if (comm)
                    begin
                        if (ol_div_q >= ol_rate_q)
                            mode_q <= ST_CLOSED;
                        else
                        begin
                            ol_div_q <= ol_div_q + 16'd1;
                            ol_per_q <= 16'(OL_BASE / (32'(ol_div_q) + 1));
                        end
                    end
                default: ;
            endcase
        end
    end

    // six-step gate pattern: pwm high leg, steady low leg, one leg off
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            gate_o <= '0;
        else if (mode_q == ST_IDLE)
            gate_o <= '0;
        else
        begin
            gate_o.hi <= pwm_on ? hi_leg(step_q) : 3'b000;
            gate_o.lo <= lo_leg(step_q);
        end
    end

    function automatic logic [2:0] hi_leg(input logic [2:0] s);
        if (s <= 3'd1)      return 3'b001;
        else if (s <= 3'd3) return 3'b100;
        else                return 3'b010;
    endfunction
    function automatic logic [2:0] lo_leg(input logic [2:0] s);
        if (s == 3'd0 || s == 3'd5) return 3'b100;
        else if (s <= 3'd2)         return 3'b010;
        else                        return 3'b001;
    endfunction

    // sticky interrupts; hardware set wins over write-one clear
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_COMM] = comm;
        irq_set[IRQ_OC] = !oc_q && (cur_s[1] >= oc_ref);
        irq_set[IRQ_CLOSED] = comm && mode_q == ST_OPEN
                              && ol_div_q >= ol_rate_q;
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_q <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~((avs_write && !ack_q
                && avs_address == REG_IRQ_STAT)
                ? avs_writedata[IRQ_W-1:0] : '0)) | irq_set;
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    property p_two_legs;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (gate_o.hi & gate_o.lo) == 3'b000;
    endproperty
    a_two_legs: assert property (p_two_legs)
        else $error("leg shorted");

    property p_clamp;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        duty_eff <= duty_max_q;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("duty over ceiling");

    property p_oc_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        oc_q && !new_cyc |=> gate_o.hi == 3'b000;
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("pwm on during overcurrent");

    property p_comm_clear;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        comm && run_q |=> acc_q == '0 && step_q != $past(step_q);
    endproperty
    a_comm_clear: assert property (p_comm_clear)
        else $error("commutation did not advance");

    property p_sample;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        adc_start_o |=> !adc_start_o;
    endproperty
    a_sample: assert property (p_sample)
        else $error("double trigger");

    property p_align_ramp;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        run_q && mode_q == ST_ALIGN && new_cyc && align_pct_q < align_max_q
            |=> align_pct_q == $past(align_pct_q) + 7'd1;
    endproperty
    a_align_ramp: assert property (p_align_ramp)
        else $error("alignment duty did not step");
endmodule

/* test/sbc_motor_model.sv */
// behavioural inverter, windings and converter answering sample requests
module sbc_motor_model
    import sbc_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             start_i,
    input  wire logic [1:0]       chan_i,
    input  wire logic [ADC_W-1:0] cur_lvl_i,
    output logic [ADC_W-1:0]      phase_o,
    output logic [ADC_W-1:0]      bus_o,
    output logic [ADC_W-1:0]      cur_o,
    output logic                  valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]       dly_q;
    logic [ADC_W-1:0] ramp_q;
    logic [1:0]       chan_q;
    logic             fall_q;
    // conversion answered five cycles after each start pulse
    always_ff @(posedge ref_clk_i)
    begin
        chan_q  <= chan_i;
        dly_q   <= rst_n_i ? {dly_q[2:0], start_i} : 4'h0;
        valid_o <= rst_n_i & dly_q[3];
        // odd steps see a falling open phase; first change is step 0
        if (!rst_n_i)
            fall_q <= 1'b1;
        else if (chan_i != chan_q)
            fall_q <= ~fall_q;
        if (!rst_n_i || chan_i != chan_q)
            ramp_q <= 10'h000; // rising open phase starts below center tap, falling one above it
        else if (dly_q[3])
            ramp_q <= (ramp_q > 10'h3BF) ? ADC_FULL : ramp_q + 10'h040;
    end
    // outside a sample the phase line shows the inverse and the bus line 10'h0CF, never a stale match
    assign phase_o = (valid_o ^ fall_q) ? ramp_q : ~ramp_q;
    assign bus_o   = valid_o ? 10'h300 : 10'h0CF;
    // sense amplifier drives its line continuously
    assign cur_o   = cur_lvl_i;
endmodule

/* test/sbc_commutator_tb_top.sv */
// self-checking bench of the commutator over its register bus
module sbc_commutator_tb_top
    import sbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 0, rst_n_i = 0, avs_read = 0, avs_write = 0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, adc_valid_i, adc_start_o, irq_o;
    logic [9:0]  adc_phase_i, adc_bus_i, adc_current_i, cur_lvl = 10'h000;
    logic [1:0]  adc_chan_o, ch;
    sbc_gate_t   gate_o, lo_prev;
    int          mismatches = 0, n_compared = 0, gate_bad = 0, cnt, n1, n2;
    logic [9:0]  refs [3] = '{OC_REF_1V5, OC_REF_2V0, OC_REF_2V5};
    logic [1:0]  ch_prev;

    sbc_commutator #(.PWM_PERIOD(100), .OL_BASE(24)) sbc_commutator_inst (
        .ref_clk_i,
        .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .adc_phase_i, .adc_bus_i,
        .adc_valid_i, .adc_current_i, .adc_start_o, .adc_chan_o, .gate_o,
        .irq_o);
    sbc_motor_model sbc_motor_model_inst (.ref_clk_i, .rst_n_i,
        .start_i(adc_start_o), .chan_i(adc_chan_o), .cur_lvl_i(cur_lvl),
        .phase_o(adc_phase_i), .bus_o(adc_bus_i), .cur_o(adc_current_i),
        .valid_o(adc_valid_i));

    // 250 mhz clock
    always #2 ref_clk_i = ~ref_clk_i;

    // leg usage watched every cycle in mid-period, where outputs settle
    always @(negedge ref_clk_i)
    begin
        if (gate_o !== 6'h00 && ($countones(gate_o.lo) != 1 ||
            $countones(gate_o.hi) > 1 || (gate_o.hi & gate_o.lo) != 0))
            gate_bad++;
        if (lo_prev.lo !== 3'h0 && gate_o.lo !== 3'h0 &&
            gate_o.lo !== lo_prev.lo && adc_chan_o === ch_prev)
            gate_bad++;
        lo_prev = gate_o;
        ch_prev = adc_chan_o;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low at an edge
    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0)
            mismatches++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp(q & m, exp);
    endtask

    // cycles of two whole steps, so rising and falling phases both count
    task automatic step_len(output int n);
        ch = adc_chan_o;
        n = 0;
        while (adc_chan_o === ch && n < 20000) @(negedge ref_clk_i) n++;
        n = 0;
        repeat (2)
        begin
            ch = adc_chan_o;
            while (adc_chan_o === ch && n < 20000) @(negedge ref_clk_i) n++;
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog, well past the expected run length
    initial
    begin
        repeat (60000) @(posedge ref_clk_i);
        mismatches++;
        final_report();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        cmp(gate_o, 6'h00);
        rd_chk(REG_FLUX, 32'hFFFFFF, FLUX_RST);
        rd_chk(REG_DUTY_MAX, 32'hFFFF, DUTY_MAX_RST);
        rd_chk(REG_ALIGN_MAX, 32'h7F, ALIGN_MAX_RST);
        rd_chk(REG_OL_RATE, 32'hFFFF, OL_RATE_RST);
        rd_chk(REG_IRQ_STAT, 32'h7, 32'h0);
        xfer(1'b1, 4'hC, 32'hFFFFFFFF);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, REG_FLUX, 32'h100);
        xfer(1'b1, REG_OL_RATE, 32'h6);
        xfer(1'b1, REG_DUTY_MAX, 32'd40);
        xfer(1'b1, REG_DUTY_CMD, 32'd80);
        xfer(1'b1, REG_IRQ_MASK, 32'h7);
        xfer(1'b1, REG_CTRL, 32'h1);
        rd_chk(REG_STATUS, 32'h3, ST_ALIGN);
        cnt = 0;
        do
        begin
            repeat (20) @(posedge ref_clk_i);
            xfer(1'b0, REG_STATUS, 32'h0);
            cnt++;
        end
        while (q[1:0] !== ST_CLOSED && cnt < 1000);
        cmp(q[1:0], ST_CLOSED);
        rd_chk(REG_IRQ_STAT, 32'h4, 32'h4);
        cnt = 0;
        repeat (1000) @(negedge ref_clk_i) cnt += (adc_start_o === 1'b1);
        cmp(cnt, 10);
        cnt = 0;
        repeat (100) @(negedge ref_clk_i) cnt += (gate_o.hi !== 3'h0);
        cmp(cnt, 40);
        xfer(1'b1, REG_DUTY_CMD, 32'd20);
        repeat (100) @(posedge ref_clk_i);
        cnt = 0;
        repeat (100) @(negedge ref_clk_i) cnt += (gate_o.hi !== 3'h0);
        cmp(cnt, 20);
        // step field advances by one at each open-phase change
        xfer(1'b0, REG_STATUS, 32'h0);
        n1 = (q[9:7] + 1) % 6;
        xfer(1'b1, REG_IRQ_STAT, 32'h1);
        ch = adc_chan_o;
        cnt = 0;
        while (adc_chan_o === ch && cnt < 20000) @(negedge ref_clk_i) cnt++;
        rd_chk(REG_STATUS, 32'h380, n1 << 7);
        rd_chk(REG_IRQ_STAT, 32'h1, 32'h1);
        step_len(n1);
        xfer(1'b1, REG_FLUX, 32'h400);
        step_len(n2);
        step_len(n2);
        cmp(n1 < n2, 1'b1);
        // each comparator level: below it no trip, above it pwm stops
        for (int s = 0; s < 3; s++)
        begin
            cur_lvl <= refs[s] - 10'h001;
            xfer(1'b1, REG_CTRL, 32'h1 | (s << 4));
            repeat (300) @(posedge ref_clk_i);
            xfer(1'b1, REG_IRQ_STAT, 32'h2);
            repeat (300) @(posedge ref_clk_i);
            rd_chk(REG_IRQ_STAT, 32'h2, 32'h0);
            cur_lvl <= refs[s] + 10'h001;
            repeat (100) @(posedge ref_clk_i);
            cnt = 0;
            repeat (200) @(negedge ref_clk_i) cnt += (gate_o.hi !== 3'h0);
            cmp(cnt, 0);
            rd_chk(REG_IRQ_STAT, 32'h2, 32'h2);
        end
        cur_lvl <= 10'h000;
        xfer(1'b1, REG_IRQ_MASK, 32'h0);
        repeat (3) @(posedge ref_clk_i);
        cmp(irq_o, 1'b0);
        xfer(1'b1, REG_IRQ_MASK, 32'h7);
        repeat (3) @(posedge ref_clk_i);
        cmp(irq_o, 1'b1);
        xfer(1'b1, REG_CTRL, 32'h0);
        repeat (300) @(posedge ref_clk_i);
        xfer(1'b1, REG_IRQ_STAT, 32'h7);
        rd_chk(REG_IRQ_STAT, 32'h7, 32'h0);
        repeat (3) @(posedge ref_clk_i);
        cmp(irq_o, 1'b0);
        cmp(gate_o, 6'h00);
        cmp(gate_bad, 0);
        final_report();
    end
endmodule
